// ### asl_map.svh
// Purpose: Offsets, field positions, reset values and timing for the
//          adapter status LED driver.
// Assumes: 8-bit register address, 32-bit register data.
// Notes:   Times are kept in their own unit; cycle counts derive in code.
`ifndef ASL_MAP_SVH
`define ASL_MAP_SVH

// ==========================================================
// Register offsets
`define ASL_ADDR_MOD 8'h00
`define ASL_ADDR_NET 8'h04
`define ASL_ADDR_IDENT 8'h08
`define ASL_ADDR_STATUS 8'h0C

// ==========================================================
// Field positions
`define ASL_MOD_DONE 0
`define ASL_MOD_CONFIGURED 1
`define ASL_MOD_RECOV 2
`define ASL_MOD_UNRECOV 3
`define ASL_NET_IP 0
`define ASL_NET_CONN 1
`define ASL_NET_EO_TMO 2
`define ASL_NET_DUP_IP 3
`define ASL_ID_START 0
`define ASL_ID_STOP 1

// ==========================================================
// Reset values
`define ASL_MOD_RST 4'h0
`define ASL_NET_RST 4'h0

// ==========================================================
// Timing
`define ASL_CLK_PS 8000
`define ASL_MS_PS 1000000000
`define ASL_BLINK_HALF_MS 500
`define ASL_POST_STEP_MS 250
`define ASL_ID_STEP_MS 500
`define ASL_ID_REPEATS 6
`define ASL_ACT_HALF_MS 50

`endif

// ### asl_pkg.sv
// Purpose: Types for the adapter status LED driver.
// Assumes: Two Ethernet ports.
// Notes:   Constants live in asl_map.svh.
package asl_pkg;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic red;
        logic green;
    } asl_duo_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } asl_bus_req_t;

    typedef struct packed {
        logic link;
        logic frame;
    } asl_port_t;

    // ==========================================================
    // Sequencer states
    typedef enum logic [3:0] {
        ASL_POST_GRN = 4'b0001,
        ASL_POST_RED = 4'b0010,
        ASL_POST_HOLD = 4'b0100,
        ASL_RUN = 4'b1000
    } asl_fsm_t;

    typedef struct packed {
        logic on;
        logic off;
        logic pend;
        logic [5:0] ms;
    } asl_act_t;

    typedef struct packed {
        logic [16:0] tick_cnt;
        logic tick;
        logic [9:0] blink_ms;
        asl_fsm_t fsm;
        logic [7:0] post_ms;
        logic id_run;
        logic [1:0] id_phase;
        logic [8:0] id_ms;
        logic [2:0] id_rep;
        logic [3:0] mod_ctrl;
        logic [3:0] net_ctrl;
        asl_act_t [1:0] act;
        logic [1:0] link_led;
        logic [1:0] traffic_led;
        asl_duo_t ms_led;
        asl_duo_t ns_led;
        logic [31:0] rdata;
    } asl_state_t;

endpackage

// ### asl_led_driver.sv
// Purpose: Health, link and traffic LED patterns for the adapter stack.
// Assumes: Firmware writes status conditions over the register port.
// Notes:   All pattern timing runs from one millisecond tick.
//          Self-test ends only when firmware sets the done bit.
//
// Contract
// [RL1] Operating: module LED steady green
// [RL2] Unconfigured: module LED green 1 Hz
// [RL3] 1 Hz means 500 ms on/off
// [RL4] Self-test module: green, red, hold green
// [RL5] Self-test network: green, red, then off
// [RL6] Identify: red, green, off, six cycles
// [RL7] Identify on request, both LEDs lockstep
// [RL8] Recoverable fault: module LED red 1 Hz
// [RL9] Unrecoverable fault: module LED steady red
// [RL10] IP and connection: network steady green
// [RL11] IP, no connection: network green 1 Hz
// [RL12] Owner timeout: network red 1 Hz
// [RL13] Green again only after all reestablished
// [RL14] Duplicate IP: network steady red
// [RL15] No IP: network LED off
// [RL16] Link LED follows each port's link
// [RL17] Traffic LED flickers on frames only
// [RL18] Heavy traffic 50 ms on/off
// [RL19] Millisecond tick timing, counters reset
`timescale 1ns/1ps
`include "asl_map.svh"

module asl_led_driver #(
    parameter int unsigned TICK_CYCLES = `ASL_MS_PS / `ASL_CLK_PS
) (
    input wire logic clk,                              // System clock
    input wire logic rst_b,                            // Async reset
    input wire asl_pkg::asl_bus_req_t bus_req,         // Register request
    output logic [31:0] bus_rdata,                     // Read data
    input wire asl_pkg::asl_port_t [1:0] port_in,      // Per-port status
    output asl_pkg::asl_duo_t module_health_led,       // Module LED
    output asl_pkg::asl_duo_t network_health_led,      // Network LED
    output logic [1:0] link_led,                       // Green link LEDs
    output logic [1:0] traffic_led                     // Yellow LEDs
);
    import asl_pkg::*;

    // ==========================================================
    // Derived counts
    // Counters stop one short, so a step lasts its full count
    localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
    localparam logic [9:0] BLINK_LAST = 10'(2 * `ASL_BLINK_HALF_MS - 1);
    localparam logic [9:0] BLINK_HALF = 10'(`ASL_BLINK_HALF_MS);
    localparam logic [7:0] POST_LAST = 8'(`ASL_POST_STEP_MS - 1);
    localparam logic [8:0] ID_LAST = 9'(`ASL_ID_STEP_MS - 1);
    localparam logic [2:0] ID_REP_LAST = 3'(`ASL_ID_REPEATS - 1);
    localparam logic [5:0] ACT_LAST = 6'(`ASL_ACT_HALF_MS - 1);

    localparam asl_duo_t LED_OFF = '{red: 1'b0, green: 1'b0};
    localparam asl_duo_t LED_GRN = '{red: 1'b0, green: 1'b1};
    localparam asl_duo_t LED_RED = '{red: 1'b1, green: 1'b0};

    // Power-on restarts self-test with firmware state cleared
    localparam asl_state_t RST_S = '{
        fsm: ASL_POST_GRN,
        mod_ctrl: `ASL_MOD_RST,
        net_ctrl: `ASL_NET_RST,
        default: '0
    };

    asl_state_t s_q;
    asl_state_t s_d;

    logic blink_on;
    asl_duo_t blink_grn;
    asl_duo_t blink_red;
    asl_duo_t id_led;
    logic [31:0] status_word;

    // ==========================================================
    // Pattern helpers
    // One shared phase keeps all 1 Hz LEDs in step
    // [RL3] Half period split
    assign blink_on = (s_q.blink_ms < BLINK_HALF);
    assign blink_grn = blink_on ? LED_GRN : LED_OFF;
    assign blink_red = blink_on ? LED_RED : LED_OFF;

    // Phase 3 never occurs; it would show off
    // [RL6] Identify phase colour
    always_comb begin
        case (s_q.id_phase)
            2'h0: id_led = LED_RED;
            2'h1: id_led = LED_GRN;
            default: id_led = LED_OFF;
        endcase
    end

    // Live display state, for diagnostics
    assign status_word = {
        16'h0,
        s_q.id_rep,
        s_q.id_run,
        s_q.fsm,
        s_q.traffic_led,
        s_q.link_led,
        s_q.ns_led.red,
        s_q.ns_led.green,
        s_q.ms_led.red,
        s_q.ms_led.green
    };

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        s_d.rdata = 32'h0;

        // One divider, so every pattern shares a time base
        // [RL19] Millisecond tick
        if (s_q.tick_cnt == TICK_LAST) begin
            s_d.tick_cnt = 17'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 17'h1;
        end

        // [RL3] Shared 1 Hz phase
        if (s_q.tick) begin
            if (s_q.blink_ms == BLINK_LAST) begin
                s_d.blink_ms = 10'h0;
            end else begin
                s_d.blink_ms = s_q.blink_ms + 10'h1;
            end
        end

        // [RL4] Self-test sequencing
        case (s_q.fsm)
            ASL_POST_GRN: begin
                if (s_q.tick) begin
                    if (s_q.post_ms == POST_LAST) begin
                        s_d.post_ms = 8'h0;
                        s_d.fsm = ASL_POST_RED;
                    end else begin
                        s_d.post_ms = s_q.post_ms + 8'h1;
                    end
                end
            end

            ASL_POST_RED: begin
                if (s_q.tick) begin
                    if (s_q.post_ms == POST_LAST) begin
                        s_d.post_ms = 8'h0;
                        s_d.fsm = ASL_POST_HOLD;
                    end else begin
                        s_d.post_ms = s_q.post_ms + 8'h1;
                    end
                end
            end

            ASL_POST_HOLD: begin
                // Waits for firmware, however long the test takes
                if (s_q.mod_ctrl[`ASL_MOD_DONE]) begin
                    s_d.fsm = ASL_RUN;
                end
            end

            // Only a reset brings the self-test back
            ASL_RUN: begin
                s_d.fsm = ASL_RUN;
            end

            // Illegal codes recover through the first step
            default: begin
                s_d.fsm = ASL_POST_GRN;
                s_d.post_ms = 8'h0;
            end
        endcase

        // Runs during self-test too; only display waits
        // [RL6] Identify sequencer
        if (s_q.id_run && s_q.tick) begin
            if (s_q.id_ms == ID_LAST) begin
                s_d.id_ms = 9'h0;
                if (s_q.id_phase == 2'h2) begin
                    s_d.id_phase = 2'h0;
                    if (s_q.id_rep == ID_REP_LAST) begin
                        s_d.id_run = 1'b0;
                        s_d.id_rep = 3'h0;
                    end else begin
                        s_d.id_rep = s_q.id_rep + 3'h1;
                    end
                end else begin
                    s_d.id_phase = s_q.id_phase + 2'h1;
                end
            end else begin
                s_d.id_ms = s_q.id_ms + 9'h1;
            end
        end

        // ==========================================================
        // Register writes, after the sequencer so a start wins
        if (bus_req.wr) begin
            case (bus_req.addr)
                `ASL_ADDR_MOD: begin
                    s_d.mod_ctrl = bus_req.wdata[3:0];
                end

                `ASL_ADDR_NET: begin
                    // [RL13] Firmware keeps timeout set until all back
                    s_d.net_ctrl = bus_req.wdata[3:0];
                end

                // A start while running restarts from red
                `ASL_ADDR_IDENT: begin
                    // [RL7] Scanner request starts identify
                    if (bus_req.wdata[`ASL_ID_START]) begin
                        s_d.id_run = 1'b1;
                        s_d.id_phase = 2'h0;
                        s_d.id_ms = 9'h0;
                        s_d.id_rep = 3'h0;
                    end else if (bus_req.wdata[`ASL_ID_STOP]) begin
                        s_d.id_run = 1'b0;
                        s_d.id_phase = 2'h0;
                        s_d.id_ms = 9'h0;
                        s_d.id_rep = 3'h0;
                    end
                end

                // Unmapped offsets are ignored
                default: begin
                    s_d.id_run = s_d.id_run;
                end
            endcase
        end

        // Register reads, data valid only in the next cycle
        // Zero elsewhere, so the bus can be ORed
        if (bus_req.rd) begin
            case (bus_req.addr)
                `ASL_ADDR_MOD: s_d.rdata = {28'h0, s_q.mod_ctrl};
                `ASL_ADDR_NET: s_d.rdata = {28'h0, s_q.net_ctrl};
                `ASL_ADDR_IDENT: s_d.rdata = {31'h0, s_q.id_run};
                `ASL_ADDR_STATUS: s_d.rdata = status_word;
                default: s_d.rdata = 32'h0;
            endcase
        end

        // ==========================================================
        // Ethernet port LEDs
        for (int i = 0; i < 2; i++) begin
            // [RL16] Link follows port
            s_d.link_led[i] = port_in[i].link;

            // Frames while lit only book the next flash;
            // the off half always runs in full
            // [RL17] Frames start a flash
            if (s_q.act[i].on || s_q.act[i].off) begin
                if (port_in[i].frame) begin
                    s_d.act[i].pend = 1'b1;
                end

                // [RL18] Fixed 50 ms halves
                if (s_q.tick) begin
                    if (s_q.act[i].ms == ACT_LAST) begin
                        s_d.act[i].ms = 6'h0;
                        if (s_q.act[i].on) begin
                            s_d.act[i].on = 1'b0;
                            s_d.act[i].off = 1'b1;
                        end else begin
                            // Off half ends: another flash if busy
                            s_d.act[i].off = 1'b0;
                            s_d.act[i].on = s_d.act[i].pend;
                            s_d.act[i].pend = 1'b0;
                        end
                    end else begin
                        s_d.act[i].ms = s_q.act[i].ms + 6'h1;
                    end
                end
            end else if (port_in[i].frame) begin
                // Light traffic: one flash per burst, irregular
                s_d.act[i].on = 1'b1;
                s_d.act[i].ms = 6'h0;
            end
            s_d.traffic_led[i] = s_q.act[i].on;
        end

        // ==========================================================
        // Health LED selection
        case (s_q.fsm)
            ASL_POST_GRN: begin
                // [RL4] First step green
                s_d.ms_led = LED_GRN;
                // [RL5] First step green
                s_d.ns_led = LED_GRN;
            end

            ASL_POST_RED: begin
                // [RL4] Second step red
                s_d.ms_led = LED_RED;
                // [RL5] Second step red
                s_d.ns_led = LED_RED;
            end

            ASL_POST_HOLD: begin
                // [RL4] Hold green
                s_d.ms_led = LED_GRN;
                // [RL5] Hold off
                s_d.ns_led = LED_OFF;
            end

            // Run: identify overrides every condition
            default: begin
                if (s_q.id_run) begin
                    // [RL7] Both LEDs lockstep
                    s_d.ms_led = id_led;
                    s_d.ns_led = id_led;
                end else begin
                    if (s_q.mod_ctrl[`ASL_MOD_UNRECOV]) begin
                        // [RL9] Steady red
                        s_d.ms_led = LED_RED;
                    end else if (s_q.mod_ctrl[`ASL_MOD_RECOV]) begin
                        // [RL8] Red flashing
                        s_d.ms_led = blink_red;
                    end else if (!s_q.mod_ctrl[`ASL_MOD_CONFIGURED]) begin
                        // [RL2] Green flashing
                        s_d.ms_led = blink_grn;
                    end else begin
                        // [RL1] Steady green
                        s_d.ms_led = LED_GRN;
                    end

                    // Duplicate address shows only with an address
                    if (!s_q.net_ctrl[`ASL_NET_IP]) begin
                        // [RL15] Off without address
                        s_d.ns_led = LED_OFF;
                    end else if (s_q.net_ctrl[`ASL_NET_DUP_IP]) begin
                        // [RL14] Steady red
                        s_d.ns_led = LED_RED;
                    end else if (s_q.net_ctrl[`ASL_NET_EO_TMO]) begin
                        // [RL12] Red flashing
                        // [RL13] Timeout outranks connections
                        s_d.ns_led = blink_red;
                    end else if (s_q.net_ctrl[`ASL_NET_CONN]) begin
                        // [RL10] Steady green
                        s_d.ns_led = LED_GRN;
                    end else begin
                        // [RL11] Green flashing
                        s_d.ns_led = blink_grn;
                    end
                end
            end
        endcase
    end

    // ==========================================================
    // State register
    // Async, so LEDs go dark even with no clock
    // [RL19] Counters restart
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= RST_S;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    // Straight from flip-flops, no glitches on LEDs
    assign bus_rdata = s_q.rdata;
    assign module_health_led = s_q.ms_led;
    assign network_health_led = s_q.ns_led;
    assign link_led = s_q.link_led;
    assign traffic_led = s_q.traffic_led;

endmodule

// ### asl_port_model.sv
// Purpose: Stand-in for the two Ethernet ports feeding link and frame lines.
// Assumes: Frame is a one-cycle pulse per frame seen.
// Notes:   Heavy mode sends a frame every 8 cycles, far faster than a flash.
`timescale 1ns/1ps
module asl_port_model (
    input wire logic clk,                     // Clock
    input wire logic rst_b,                   // Async reset
    input wire logic [1:0] link_set,          // Link present per port
    input wire logic [1:0] heavy,             // Steady traffic per port
    input wire logic [1:0] shot,              // Single frame now
    output asl_pkg::asl_port_t [1:0] port_in  // Port status lines
);
    import asl_pkg::*;
    logic [2:0] div_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            port_in[i].link = link_set[i];
            port_in[i].frame = shot[i] | (heavy[i] & (div_q == 3'h0));
        end
    end
endmodule

// ### asl_led_driver_assertions.sv
// Purpose: Port-level checks of the status LED driver.
// Assumes: Register writes shadowed here mirror the design's map.
// Notes:   Identify overrides the health LEDs, so the post-hold and run-mode health checks stop once it is requested.
`timescale 1ns/1ps
`include "asl_map.svh"
module asl_led_driver_assertions #(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic clk,                            // Clock
    input wire logic rst_b,                          // Async reset
    input wire asl_pkg::asl_bus_req_t bus_req,       // Register request
    input wire logic [31:0] bus_rdata,               // Read data
    input wire asl_pkg::asl_port_t [1:0] port_in,    // Port status
    input wire asl_pkg::asl_duo_t module_health_led, // Module LED
    input wire asl_pkg::asl_duo_t network_health_led,// Network LED
    input wire logic [1:0] link_led,                 // Link LEDs
    input wire logic [1:0] traffic_led               // Traffic LEDs
);
    import asl_pkg::*;
    // ==========================================================
    // Helper state
    logic [19:0] cyc;
    logic [3:0] mod_sh;
    logic [3:0] net_sh;
    logic id_seen;
    logic [1:0] quiet_wr;
    logic [15:0] quiet0;
    logic [15:0] on0;
    logic calm;
    assign calm = quiet_wr == 2'h3 && mod_sh[0] && !id_seen;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cyc <= 20'h0;
            mod_sh <= 4'h0;
            net_sh <= 4'h0;
            id_seen <= 1'b0;
            quiet_wr <= 2'h0;
            quiet0 <= 16'h0;
            on0 <= 16'h0;
        end else begin
            cyc <= (cyc == 20'hFFFFF) ? cyc : cyc + 20'h1;
            if (bus_req.wr && bus_req.addr == `ASL_ADDR_MOD) begin
                mod_sh <= bus_req.wdata[3:0];
            end
            if (bus_req.wr && bus_req.addr == `ASL_ADDR_NET) begin
                net_sh <= bus_req.wdata[3:0];
            end
            if (bus_req.wr && bus_req.addr == `ASL_ADDR_IDENT && bus_req.wdata[0]) begin
                id_seen <= 1'b1;
            end
            quiet_wr <= bus_req.wr ? 2'h0 : ((quiet_wr == 2'h3) ? quiet_wr : quiet_wr + 2'h1);
            quiet0 <= port_in[0].frame ? 16'h0 : ((quiet0 == 16'hFFFF) ? quiet0 : quiet0 + 16'h1);
            on0 <= traffic_led[0] ? on0 + 16'h1 : 16'h0;
        end
    end
    // ==========================================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_post_green: assert property (cyc >= 2 && cyc < 240 * TICK_CYCLES
        |-> module_health_led == 2'b01 && network_health_led == 2'b01) else $error("post green");
    a_post_red: assert property (cyc > 260 * TICK_CYCLES && cyc < 490 * TICK_CYCLES
        |-> module_health_led == 2'b10 && network_health_led == 2'b10) else $error("post red");
    a_post_hold: assert property (cyc > 510 * TICK_CYCLES && !mod_sh[0] && !id_seen
        |-> module_health_led == 2'b01 && network_health_led == 2'b00) else $error("post hold");
    a_no_ip_off: assert property (calm && !net_sh[0]
        |-> network_health_led == 2'b00) else $error("net lit without ip");
    a_unrecov_red: assert property (calm && mod_sh[3]
        |-> module_health_led == 2'b10) else $error("module not red");
    a_dup_red: assert property (calm && net_sh[0] && net_sh[3]
        |-> network_health_led == 2'b10) else $error("dup ip not red");
    a_conn_green: assert property (calm && net_sh == 4'h3
        |-> network_health_led == 2'b01) else $error("net not green");
    a_link_follow: assert property ($changed(port_in[1].link)
        |=> link_led[1] == $past(port_in[1].link)) else $error("link led lag");
    a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
        else $error("read data outside slot");
    a_unmapped_rd: assert property (bus_req.rd && bus_req.addr >= 8'h10
        |=> bus_rdata == 32'h0) else $error("unmapped read");
    a_flash_fire: assert property (quiet0 > 210 * TICK_CYCLES && port_in[0].frame
        |-> ##[1:2] traffic_led[0]) else $error("frame did not light");
    a_flash_len: assert property ($fell(traffic_led[0])
        |-> on0 >= 49 * TICK_CYCLES && on0 <= 51 * TICK_CYCLES) else $error("flash length");
endmodule
bind asl_led_driver asl_led_driver_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata), .port_in(port_in),
    .module_health_led(module_health_led), .network_health_led(network_health_led),
    .link_led(link_led), .traffic_led(traffic_led));

// ### test_asl_led_driver.sv
// Purpose: Self-checking bench for the adapter status LED driver.
// Assumes: Millisecond tick shortened to 2 clocks.
// Notes:   LED times are measured by counting lit cycles over a window.
`timescale 1ns/1ps
`include "asl_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_asl_led_driver;
    import asl_pkg::*;
    localparam int unsigned T = 2;
    logic clk = 1'b0;
    logic rst_b;
    asl_bus_req_t bus_req;
    logic [31:0] bus_rdata;
    asl_port_t [1:0] port_in;
    asl_duo_t ms_led;
    asl_duo_t ns_led;
    logic [1:0] link_led;
    logic [1:0] traffic_led;
    logic [1:0] link_set;
    logic [1:0] heavy;
    logic [1:0] shot;
    int failures = 0;
    int n_tests = 0;
    int c[6];
    wire [5:0] s = {traffic_led, ms_led, ns_led};
    always #4 clk = ~clk;
    asl_led_driver #(.TICK_CYCLES(T)) dut (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .port_in(port_in), .module_health_led(ms_led),
        .network_health_led(ns_led), .link_led(link_led), .traffic_led(traffic_led));
    asl_port_model u_ports (.clk(clk), .rst_b(rst_b), .link_set(link_set), .heavy(heavy),
        .shot(shot), .port_in(port_in));
    // ==========================================================
    // Helpers
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask
    task automatic cnt(input int n);
        for (int k = 0; k < 6; k++) c[k] = 0;
        repeat (n) begin
            waitc(1);
            for (int k = 0; k < 6; k++) if (s[k] === 1'b1) c[k]++;
        end
    endtask
    function automatic bit near(input int a, input int e, input int t);
        return a >= e - t && a <= e + t;
    endfunction
    // Window of 2000 cycles is one full second at this tick
    task automatic mode_case(input logic [7:0] a, input logic [3:0] v, input int mg,
        input int mr, input int ng, input int nr);
        wr(a, {28'h0, v});
        waitc(4);
        cnt(2000);
        `CHK(near(c[2], mg, 8), 1'b1)
        `CHK(near(c[3], mr, 8), 1'b1)
        `CHK(near(c[0], ng, 8), 1'b1)
        `CHK(near(c[1], nr, 8), 1'b1)
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_selftest();
        waitc(200);
        `CHK(s[3:0], 4'h5)
        waitc(550);
        `CHK(s[3:0], 4'hA)
        waitc(450);
        `CHK(s[3:0], 4'h4)
        $display("selftest done");
    endtask
    task automatic t_regs();
        logic [31:0] d;
        wr(`ASL_ADDR_MOD, 32'hFFFF_FFF3);
        rd(`ASL_ADDR_MOD, d);
        `CHK(d, 32'h3)
        wr(8'h10, 32'hF);
        rd(8'h10, d);
        `CHK(d, 32'h0)
        rd(`ASL_ADDR_STATUS, d);
        `CHK(d[11:8], 4'h8)
        $display("registers done");
    endtask
    task automatic t_modes();
        mode_case(`ASL_ADDR_MOD, 4'h3, 2000, 0, 0, 0);
        mode_case(`ASL_ADDR_MOD, 4'h1, 1000, 0, 0, 0);
        mode_case(`ASL_ADDR_MOD, 4'h7, 0, 1000, 0, 0);
        mode_case(`ASL_ADDR_MOD, 4'hF, 0, 2000, 0, 0);
        mode_case(`ASL_ADDR_MOD, 4'h3, 2000, 0, 0, 0);
        mode_case(`ASL_ADDR_NET, 4'h1, 2000, 0, 1000, 0);
        mode_case(`ASL_ADDR_NET, 4'h3, 2000, 0, 2000, 0);
        mode_case(`ASL_ADDR_NET, 4'h7, 2000, 0, 0, 1000);
        mode_case(`ASL_ADDR_NET, 4'h3, 2000, 0, 2000, 0);
        mode_case(`ASL_ADDR_NET, 4'hB, 2000, 0, 0, 2000);
        mode_case(`ASL_ADDR_NET, 4'h8, 2000, 0, 0, 0);
        mode_case(`ASL_ADDR_NET, 4'h3, 2000, 0, 2000, 0);
        $display("modes done");
    endtask
    task automatic t_ports();
        @(posedge clk) link_set <= 2'b01;
        waitc(3);
        `CHK(link_led, 2'b01)
        @(posedge clk) link_set <= 2'b10;
        waitc(3);
        `CHK(link_led, 2'b10)
        `CHK(traffic_led, 2'b00)
        @(posedge clk) shot <= 2'b01;
        @(posedge clk) shot <= 2'b00;
        waitc(50);
        `CHK(traffic_led, 2'b01)
        waitc(120);
        `CHK(traffic_led, 2'b00)
        @(posedge clk) heavy <= 2'b11;
        waitc(20);
        cnt(2000);
        `CHK(near(c[4], 1000, 40), 1'b1)
        `CHK(near(c[5], 1000, 40), 1'b1)
        @(posedge clk) heavy <= 2'b00;
        waitc(420);
        `CHK(traffic_led, 2'b00)
        $display("ports done");
    endtask
    task automatic t_ident();
        logic [31:0] d;
        wr(`ASL_ADDR_IDENT, 32'h1);
        rd(`ASL_ADDR_IDENT, d);
        `CHK(d[0], 1'b1)
        for (int r = 0; r < 6; r++) begin
            waitc(500);
            `CHK(s[3:0], 4'hA)
            waitc(1000);
            `CHK(s[3:0], 4'h5)
            waitc(1000);
            `CHK(s[3:0], 4'h0)
            waitc(500);
        end
        waitc(20);
        rd(`ASL_ADDR_IDENT, d);
        `CHK(d[0], 1'b0)
        `CHK(s[3:0], 4'h5)
        $display("identify done");
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        bus_req = '0;
        link_set = 2'b00;
        heavy = 2'b00;
        shot = 2'b00;
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_selftest();
        t_regs();
        t_modes();
        t_ports();
        t_ident();
        tally_and_finish();
    end
    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
endmodule
